// ==== src/sioad_pkg.sv ====
// Constants, types and reset state for the host address decode block.
// Assumes a 50 MHz system clock and ISA-style synchronous I/O strobes.
package sioad_pkg;

  // Configuration port pair, chosen by a strap caught after reset
  localparam logic [9:0] SIOAD_CFG_PORT_PRI = 10'h3F0;
  localparam logic [9:0] SIOAD_CFG_PORT_ALT = 10'h370;
  localparam logic [7:0] SIOAD_KEY_ENTER = 8'h55;
  localparam logic [7:0] SIOAD_KEY_EXIT = 8'hAA;

  // Configuration register indices
  localparam logic [3:0] SIOAD_CI_FLP = 4'h0;
  localparam logic [3:0] SIOAD_CI_COM1 = 4'h1;
  localparam logic [3:0] SIOAD_CI_COM2 = 4'h2;
  localparam logic [3:0] SIOAD_CI_PAR = 4'h3;
  localparam logic [3:0] SIOAD_CI_PMODE = 4'h4;
  localparam logic [3:0] SIOAD_CI_IDE1 = 4'h5;
  localparam logic [3:0] SIOAD_CI_IDE2 = 4'h6;
  localparam logic [3:0] SIOAD_CI_GAME = 4'h7;
  localparam logic [3:0] SIOAD_CI_EXTIRQ = 4'h8;
  localparam logic [3:0] SIOAD_CI_SERIRQ = 4'h9;
  localparam logic [7:0] SIOAD_CFG_RESET = 8'h00;
  localparam int SIOAD_IRQ_EN_BIT = 3;

  // Floppy register offsets
  localparam logic [2:0] SIOAD_FO_STAT_A = 3'h0;
  localparam logic [2:0] SIOAD_FO_STAT_B = 3'h1;
  localparam logic [2:0] SIOAD_FO_FIFO = 3'h5;
  localparam logic [2:0] SIOAD_FO_RSVD = 3'h6;

  // Window masks and fixed offsets
  localparam logic [9:0] SIOAD_MASK8 = 10'h007;
  localparam logic [9:0] SIOAD_MASK4 = 10'h003;
  localparam logic [9:0] SIOAD_IDE_ALT_OFS = 10'h006;
  localparam logic [9:0] SIOAD_IDE_EXCL_A = 10'h377;
  localparam logic [9:0] SIOAD_IDE_EXCL_B = 10'h3F7;
  localparam logic [2:0] SIOAD_IDE_DATA_OFS = 3'h0;

  typedef enum logic [1:0] {
    SIOAD_PM_SPP = 2'h0,
    SIOAD_PM_EPP = 2'h1,
    SIOAD_PM_ECP = 2'h2
  } sioad_pmode_e;

  typedef enum logic [1:0] {
    SIOAD_CM_IDLE = 2'b00,
    SIOAD_CM_KEY1 = 2'b01,
    SIOAD_CM_ACTIVE = 2'b11
  } sioad_cmode_e;

  typedef struct packed {
    logic strap_done;
    logic strap_alt;
    sioad_cmode_e cfg_st;
    logic [3:0] cfg_idx;
    logic [15:0][7:0] cfg;
    logic iow_q;
    logic [7:0] flp_rd;
    logic [7:0] flp_wr;
    logic com1_n;
    logic com2_n;
    logic par_n;
    logic ide0_n;
    logic ide1_n;
    logic game_n;
    logic iocs16_n;
    logic sd_oe;
    logic sd_oe_hi;
    logic [15:0] sd_out;
  } sioad_state_s;

  localparam sioad_state_s SIOAD_ST_RESET = '{
    strap_done: 1'b0, strap_alt: 1'b0, cfg_st: SIOAD_CM_IDLE, cfg_idx: 4'h0,
    cfg: {16{SIOAD_CFG_RESET}}, iow_q: 1'b1, flp_rd: 8'h00, flp_wr: 8'h00,
    com1_n: 1'b1, com2_n: 1'b1, par_n: 1'b1, ide0_n: 1'b1, ide1_n: 1'b1,
    game_n: 1'b1, iocs16_n: 1'b1, sd_oe: 1'b0, sd_oe_hi: 1'b0, sd_out: 16'h0000};

endpackage

// ==== src/sioad_decode.sv ====
// Host I/O address decode, configuration port and interrupt steering.
// Assumes ISA strobes synchronous to CLK; pads tri-state from the enables.
`timescale 1ns/1ps
module sioad_decode
  import sioad_pkg::*;
(
  input wire logic CLK,
  input wire logic NRST,
  input wire logic POWER_VALID,
  input wire logic CFG_ALT_STRAP,
  input wire logic [10:0] SA,
  input wire logic AEN,
  input wire logic IOR_N,
  input wire logic IOW_N,
  input wire logic DACK_N,
  input wire logic [15:0] SD_IN,
  output logic [15:0] SD_OUT,
  output logic SD_OE,
  output logic SD_OE_HI,
  input wire logic [15:0] FUNC_RD_DATA,
  output logic [7:0] FLP_RD,
  output logic [7:0] FLP_WR,
  output logic COM1_SEL_N,
  output logic COM2_SEL_N,
  output logic PAR_SEL_N,
  output logic IDE_CS0_N,
  output logic IDE_CS1_N,
  output logic GAME_PORT_SELECT_N,
  output logic IOCS16_N,
  output logic CFG_MODE,
  output logic PINS_OE,
  input wire logic EXTERNAL_IRQ_INPUT,
  input wire logic SERIAL_IRQ,
  input wire logic RING_INDICATOR_IN,
  output logic RING_INDICATOR_OUT,
  output logic [7:0] STEERED_IRQ_OUTPUTS,
  output logic [7:0] IRQ_OE
);

  sioad_state_s s_r;
  sioad_state_s s_nxt;
  logic io;
  logic wr_edge;
  logic [9:0] cfg_port;
  logic cfg_idx_hit;
  logic cfg_dat_hit;
  logic game_hit;
  logic ide_alt_hit;

  // Window hit on a programmed base; zero base means disabled
  function automatic logic win_hit(input logic [9:0] a, input logic [7:0] base,
                                   input logic [9:0] mask);
    win_hit = (base != 8'h00) && (((a ^ {base, 2'b00}) & ~mask) == 10'h000);
  endfunction

  assign io = !AEN && !SA[10];
  assign wr_edge = s_r.iow_q && !IOW_N;
  assign cfg_port = s_r.strap_alt ? SIOAD_CFG_PORT_ALT : SIOAD_CFG_PORT_PRI;
  assign cfg_idx_hit = io && (SA[9:0] == cfg_port);
  assign cfg_dat_hit = io && (SA[9:0] == (cfg_port | 10'h001));
  assign game_hit = io && win_hit(SA[9:0], s_r.cfg[SIOAD_CI_GAME], SIOAD_MASK4);
  assign ide_alt_hit = io && (s_r.cfg[SIOAD_CI_IDE2] != 8'h00)
    && (SA[9:0] == ({s_r.cfg[SIOAD_CI_IDE2], 2'b00} + SIOAD_IDE_ALT_OFS))
    && (SA[9:0] != SIOAD_IDE_EXCL_A) && (SA[9:0] != SIOAD_IDE_EXCL_B);

  always_comb begin
    logic [2:0] off;
    logic flp_hit;
    logic blocked;
    logic par_hit;
    logic any_rd;
    logic [9:0] par_mask;
    off = SA[2:0];
    any_rd = 1'b0;
    flp_hit = io && win_hit(SA[9:0], s_r.cfg[SIOAD_CI_FLP], SIOAD_MASK8);
    blocked = (s_r.cfg_st == SIOAD_CM_ACTIVE)
      && ((off == SIOAD_FO_STAT_A) || (off == SIOAD_FO_STAT_B));
    par_mask = (s_r.cfg[SIOAD_CI_PMODE][1:0] == SIOAD_PM_SPP) ? SIOAD_MASK4 : SIOAD_MASK8;
    par_hit = (io && win_hit(SA[9:0], s_r.cfg[SIOAD_CI_PAR], par_mask))
      || (!AEN && SA[10] && (s_r.cfg[SIOAD_CI_PMODE][1:0] == SIOAD_PM_ECP)
      && win_hit(SA[9:0], s_r.cfg[SIOAD_CI_PAR], SIOAD_MASK4));
    s_nxt = s_r;
    s_nxt.iow_q = IOW_N;
    s_nxt.flp_rd = 8'h00;
    s_nxt.flp_wr = 8'h00;
    if (!s_r.strap_done) begin
      s_nxt.strap_done = 1'b1;
      s_nxt.strap_alt = CFG_ALT_STRAP;
    end
    // Configuration key sequence and data writes
    if (wr_edge && cfg_idx_hit) begin
      case (s_r.cfg_st)
        SIOAD_CM_IDLE: begin
          if (SD_IN[7:0] == SIOAD_KEY_ENTER) s_nxt.cfg_st = SIOAD_CM_KEY1;
        end
        SIOAD_CM_KEY1: begin
          s_nxt.cfg_st = (SD_IN[7:0] == SIOAD_KEY_ENTER) ? SIOAD_CM_ACTIVE : SIOAD_CM_IDLE;
        end
        SIOAD_CM_ACTIVE: begin
          if (SD_IN[7:0] == SIOAD_KEY_EXIT) s_nxt.cfg_st = SIOAD_CM_IDLE;
          else s_nxt.cfg_idx = SD_IN[3:0];
        end
        default: s_nxt.cfg_st = SIOAD_CM_IDLE;
      endcase
    end
    if (wr_edge && cfg_dat_hit && (s_r.cfg_st == SIOAD_CM_ACTIVE)) begin
      s_nxt.cfg[s_r.cfg_idx] = SD_IN[7:0];
    end
    // Floppy register strobes
    if (flp_hit && !IOR_N && (off != SIOAD_FO_RSVD) && !blocked) begin
      s_nxt.flp_rd[off] = 1'b1;
    end
    if (flp_hit && !IOW_N && (off != SIOAD_FO_RSVD) && (off != SIOAD_FO_STAT_A)
        && (off != SIOAD_FO_STAT_B)) begin
      s_nxt.flp_wr[off] = 1'b1;
    end
    if (AEN && !DACK_N) begin
      s_nxt.flp_rd[SIOAD_FO_FIFO] = !IOR_N;
      s_nxt.flp_wr[SIOAD_FO_FIFO] = !IOW_N;
    end
    s_nxt.com1_n = !(io && win_hit(SA[9:0], s_r.cfg[SIOAD_CI_COM1], SIOAD_MASK8)
      && !(IOR_N && IOW_N));
    s_nxt.com2_n = !(io && win_hit(SA[9:0], s_r.cfg[SIOAD_CI_COM2], SIOAD_MASK8)
      && !(IOR_N && IOW_N));
    s_nxt.par_n = !(par_hit && !(IOR_N && IOW_N));
    s_nxt.ide0_n = !(io && win_hit(SA[9:0], s_r.cfg[SIOAD_CI_IDE1], SIOAD_MASK8)
      && !(IOR_N && IOW_N));
    s_nxt.ide1_n = !(ide_alt_hit && !(IOR_N && IOW_N));
    s_nxt.game_n = !game_hit;
    s_nxt.iocs16_n = !(!s_nxt.ide0_n && (off == SIOAD_IDE_DATA_OFS));
    any_rd = (|s_nxt.flp_rd) || !s_nxt.com1_n || !s_nxt.com2_n || !s_nxt.par_n
      || !s_nxt.ide0_n || !s_nxt.ide1_n;
    s_nxt.sd_oe = !IOR_N && any_rd;
    s_nxt.sd_oe_hi = !IOR_N && !s_nxt.iocs16_n;
    s_nxt.sd_out = FUNC_RD_DATA;
    // Power-valid low: freeze state, release all strobes
    if (!POWER_VALID) begin
      s_nxt = s_r;
      s_nxt.flp_rd = 8'h00;
      s_nxt.flp_wr = 8'h00;
      s_nxt.com1_n = 1'b1;
      s_nxt.com2_n = 1'b1;
      s_nxt.par_n = 1'b1;
      s_nxt.ide0_n = 1'b1;
      s_nxt.ide1_n = 1'b1;
      s_nxt.game_n = 1'b1;
      s_nxt.iocs16_n = 1'b1;
      s_nxt.sd_oe = 1'b0;
      s_nxt.sd_oe_hi = 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) s_r <= SIOAD_ST_RESET;
    else s_r <= s_nxt;
  end

  assign SD_OUT = s_r.sd_out;
  assign SD_OE = s_r.sd_oe;
  assign SD_OE_HI = s_r.sd_oe_hi;
  assign FLP_RD = s_r.flp_rd;
  assign FLP_WR = s_r.flp_wr;
  assign COM1_SEL_N = s_r.com1_n;
  assign COM2_SEL_N = s_r.com2_n;
  assign PAR_SEL_N = s_r.par_n;
  assign IDE_CS0_N = s_r.ide0_n;
  assign IDE_CS1_N = s_r.ide1_n;
  assign GAME_PORT_SELECT_N = s_r.game_n;
  assign IOCS16_N = s_r.iocs16_n;
  assign CFG_MODE = (s_r.cfg_st == SIOAD_CM_ACTIVE);
  assign PINS_OE = POWER_VALID;
  assign RING_INDICATOR_OUT = RING_INDICATOR_IN;

  // Interrupt steering, one line per output
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_irq
      logic ext_sel;
      logic ser_sel;
      assign ext_sel = POWER_VALID && s_r.cfg[SIOAD_CI_EXTIRQ][SIOAD_IRQ_EN_BIT]
        && (s_r.cfg[SIOAD_CI_EXTIRQ][2:0] == 3'(gi));
      assign ser_sel = s_r.cfg[SIOAD_CI_SERIRQ][SIOAD_IRQ_EN_BIT]
        && (s_r.cfg[SIOAD_CI_SERIRQ][2:0] == 3'(gi));
      assign STEERED_IRQ_OUTPUTS[gi] = (ext_sel && EXTERNAL_IRQ_INPUT)
        || (ser_sel && SERIAL_IRQ);
      assign IRQ_OE[gi] = ext_sel || ser_sel;
    end
  endgenerate

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);

  sequence sq_key55;
    POWER_VALID && wr_edge && cfg_idx_hit && (SD_IN[7:0] == SIOAD_KEY_ENTER);
  endsequence

  sequence sq_first_key;
    s_r.cfg_st == SIOAD_CM_KEY1;
  endsequence

  sequence sq_enter;
    sq_first_key and sq_key55;
  endsequence

  chk_irq_route: assert property (
    (POWER_VALID && s_r.cfg[SIOAD_CI_EXTIRQ][SIOAD_IRQ_EN_BIT] && EXTERNAL_IRQ_INPUT)
    |-> STEERED_IRQ_OUTPUTS[s_r.cfg[SIOAD_CI_EXTIRQ][2:0]])
    else $error("external irq not steered");
  chk_pv_quiet: assert property (
    !POWER_VALID |=> (!SD_OE && FLP_RD == 8'h00 && FLP_WR == 8'h00 && GAME_PORT_SELECT_N))
    else $error("outputs active while power invalid");
  chk_pv_hold: assert property (!POWER_VALID |=> $stable(s_r.cfg))
    else $error("config changed while power invalid");
  chk_game_sel: assert property ((POWER_VALID && game_hit) |=> !GAME_PORT_SELECT_N)
    else $error("game select missing");
  chk_ide_excl: assert property (
    (SA[9:0] == SIOAD_IDE_EXCL_A || SA[9:0] == SIOAD_IDE_EXCL_B) |=> IDE_CS1_N)
    else $error("ide select on excluded address");
  chk_ser_irq: assert property (
    (SERIAL_IRQ && s_r.cfg[SIOAD_CI_SERIRQ][SIOAD_IRQ_EN_BIT])
    |-> (STEERED_IRQ_OUTPUTS[s_r.cfg[SIOAD_CI_SERIRQ][2:0]]
    && IRQ_OE[s_r.cfg[SIOAD_CI_SERIRQ][2:0]]))
    else $error("serial irq lost");
  chk_key_enter: assert property (sq_enter |=> CFG_MODE)
    else $error("key sequence did not enter config mode");
  chk_cfg_ignored: assert property ((s_r.cfg_st != SIOAD_CM_ACTIVE) |=> $stable(s_r.cfg))
    else $error("config written outside config mode");
  chk_stat_block: assert property (CFG_MODE |=> (FLP_RD[1:0] == 2'b00))
    else $error("floppy status read in config mode");
  chk_flp_off: assert property (!FLP_RD[6] && !FLP_WR[6] && FLP_WR[1:0] == 2'b00)
    else $error("floppy strobe on reserved or read-only offset");
  chk_flp_off_rst: assert property (
    (s_r.cfg[SIOAD_CI_FLP] == 8'h00 && !AEN) |=> (FLP_RD == 8'h00 && FLP_WR == 8'h00))
    else $error("floppy decode while base unset");
  chk_dma_fifo: assert property (
    (POWER_VALID && AEN && !DACK_N && !IOR_N) |=> FLP_RD[SIOAD_FO_FIFO])
    else $error("dma read strobe missing");
  chk_aen_ignore: assert property (
    AEN |=> (COM1_SEL_N && COM2_SEL_N && IDE_CS0_N && IDE_CS1_N && GAME_PORT_SELECT_N))
    else $error("decode during dma cycle");

endmodule // sioad_decode

// ==== tb/sioad_host.sv ====
// Host processor model: drives ISA I/O and DMA cycles on request.
// Assumes the bench calls start and stop just after a rising edge.
`timescale 1ns/1ps
module sioad_host (
  output logic [10:0] SA,
  output logic AEN,
  output logic IOR_N,
  output logic IOW_N,
  output logic DACK_N,
  output logic [15:0] SD_IN
);
  initial begin
    SA = 11'h000;
    AEN = 1'b0;
    IOR_N = 1'b1;
    IOW_N = 1'b1;
    DACK_N = 1'b1;
    SD_IN = 16'h0000;
  end
  // Address, strobe and data held until stop
  task automatic start(input logic [10:0] a, input logic rd, input logic [15:0] d,
                       input logic dma);
    SA = a;
    AEN = dma;
    DACK_N = ~dma;
    SD_IN = rd ? ~SD_IN : d;
    IOR_N = ~rd;
    IOW_N = rd;
  endtask
  task automatic stop();
    IOR_N = 1'b1;
    IOW_N = 1'b1;
    DACK_N = 1'b1;
    AEN = 1'b0;
    SD_IN = ~SD_IN; // Released bus shows the inverse of the value driven last
  endtask
endmodule // sioad_host

// ==== tb/tb_top.sv ====
// Self-checking bench for the host address decode block.
// Assumes the host model drives the ISA side; one 50 MHz clock.
`timescale 1ns/1ps
module tb_top;
  logic clk, nrst, pwr, ext_irq, ri_in, ri_out, cfg_mode, pins_oe, aen, ior_n, iow_n;
  logic dack_n, sd_oe, sd_oe_hi, par_n, ide0_n, ide1_n, game_n, cs16_n;
  logic strap, ser_irq, com1_n, com2_n;
  logic [10:0] sa;
  logic [15:0] sd_in, sd_out;
  logic [7:0] flp_rd, flp_wr, irq_out, irq_oe;
  int fail_count = 0;
  int cmp_count = 0;
  sioad_decode dut_u (
    .CLK(clk), .NRST(nrst), .POWER_VALID(pwr), .CFG_ALT_STRAP(strap), .SA(sa), .AEN(aen),
    .IOR_N(ior_n), .IOW_N(iow_n), .DACK_N(dack_n), .SD_IN(sd_in), .SD_OUT(sd_out),
    .SD_OE(sd_oe), .SD_OE_HI(sd_oe_hi), .FUNC_RD_DATA(16'h1234), .FLP_RD(flp_rd),
    .FLP_WR(flp_wr), .COM1_SEL_N(com1_n), .COM2_SEL_N(com2_n), .PAR_SEL_N(par_n),
    .IDE_CS0_N(ide0_n),
    .IDE_CS1_N(ide1_n), .GAME_PORT_SELECT_N(game_n), .IOCS16_N(cs16_n), .CFG_MODE(cfg_mode),
    .PINS_OE(pins_oe), .EXTERNAL_IRQ_INPUT(ext_irq), .SERIAL_IRQ(ser_irq),
    .RING_INDICATOR_IN(ri_in), .RING_INDICATOR_OUT(ri_out), .STEERED_IRQ_OUTPUTS(irq_out),
    .IRQ_OE(irq_oe));
  sioad_host host_u (.SA(sa), .AEN(aen), .IOR_N(ior_n), .IOW_N(iow_n), .DACK_N(dack_n),
    .SD_IN(sd_in));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic go(input logic [10:0] a, input logic rd, input logic [15:0] d, input logic dma);
    host_u.start(a, rd, d, dma);
    tick(2);
  endtask
  task automatic done();
    host_u.stop();
    tick(2);
  endtask
  task automatic wr(input logic [10:0] a, input logic [7:0] d);
    go(a, 1'b0, {8'h00, d}, 1'b0);
    done();
  endtask
  task automatic cfg(input logic [3:0] i, input logic [7:0] v);
    wr(11'h3F0, {4'h0, i});
    wr(11'h3F1, v);
  endtask
  task automatic enter();
    wr(11'h3F0, 8'h55);
    wr(11'h3F0, 8'h55);
  endtask
  task automatic rd_chk(input logic [10:0] a, input logic dma, output logic [7:0] r);
    go(a, 1'b1, 16'h0000, dma);
    r = game_n;
  endtask
  task automatic t_reset();
    go(11'h200, 1'b1, 16'h0000, 1'b0);
    chk(game_n, 1'b1);
    done();
    cfg(4'h7, 8'h80);
    go(11'h200, 1'b1, 16'h0000, 1'b0);
    chk({cfg_mode, game_n}, 2'b01);
    done();
    enter();
    chk(cfg_mode, 1'b1);
    cfg(4'h7, 8'h80);
    cfg(4'h0, 8'hFC);
    cfg(4'h3, 8'hDE);
    cfg(4'h5, 8'h7C);
    cfg(4'h6, 8'hFC);
    cfg(4'h1, 8'hFE);
    cfg(4'h2, 8'hBE);
    go(11'h3F0, 1'b1, 16'h0000, 1'b0);
    chk(flp_rd, 8'h00);
    done();
    wr(11'h3F0, 8'hAA);
    chk(cfg_mode, 1'b0);
    $display("test reset_and_config done");
  endtask
  task automatic fl(input logic [2:0] o, input logic rd, input logic [7:0] er,
                    input logic [7:0] ew);
    go({8'h7E, o}, rd, 16'h00A5, 1'b0);
    chk({flp_rd, flp_wr}, {er, ew});
    if (rd && er != 8'h00) chk({sd_oe, sd_out}, 17'h11234);
    done();
  endtask
  task automatic t_floppy();
    fl(3'h0, 1'b1, 8'h01, 8'h00);
    fl(3'h4, 1'b1, 8'h10, 8'h00);
    fl(3'h4, 1'b0, 8'h00, 8'h10);
    fl(3'h7, 1'b1, 8'h80, 8'h00);
    fl(3'h7, 1'b0, 8'h00, 8'h80);
    fl(3'h6, 1'b1, 8'h00, 8'h00);
    fl(3'h6, 1'b0, 8'h00, 8'h00);
    fl(3'h5, 1'b0, 8'h00, 8'h20);
    fl(3'h0, 1'b0, 8'h00, 8'h00);
    fl(3'h1, 1'b0, 8'h00, 8'h00);
    go(11'h200, 1'b1, 16'h0000, 1'b1);
    chk({game_n, flp_rd}, 9'h120);
    done();
    go(11'h200, 1'b0, 16'h005A, 1'b1);
    chk(flp_wr, 8'h20);
    done();
    $display("test floppy_and_dma done");
  endtask
  task automatic pa(input logic [10:0] a, input logic e);
    go(a, 1'b1, 16'h0000, 1'b0);
    chk(par_n, e);
    done();
  endtask
  task automatic id(input logic [10:0] a, input logic [3:0] e);
    go(a, 1'b1, 16'h0000, 1'b0);
    chk({ide0_n, ide1_n, sd_oe_hi, cs16_n}, e);
    done();
  endtask
  task automatic t_windows();
    logic [7:0] g;
    rd_chk(11'h200, 1'b0, g);
    chk(g, 8'h00);
    done();
    rd_chk(11'h204, 1'b0, g);
    chk(g, 8'h01);
    done();
    id(11'h1F0, 4'b0110);
    id(11'h1F2, 4'b0101);
    id(11'h3F6, 4'b1001);
    id(11'h3F7, 4'b1101);
    id(11'h377, 4'b1101);
    go(11'h3FA, 1'b0, 16'h0000, 1'b0);
    chk({com1_n, com2_n}, 2'b01);
    done();
    go(11'h2FF, 1'b1, 16'h0000, 1'b0);
    chk({com1_n, com2_n, sd_oe}, 3'b101);
    done();
    for (int m = 0; m < 3; m++) begin
      enter();
      cfg(4'h4, 8'(m));
      wr(11'h3F0, 8'hAA);
      pa(11'h378, 1'b0);
      pa(11'h37C, m == 0);
      pa(11'h778, m != 2);
    end
    $display("test decode_windows done");
  endtask
  task automatic t_irq_power();
    enter();
    for (int l = 0; l < 8; l++) begin
      cfg(4'h8, 8'h08 | 8'(l));
      ext_irq = 1'b1;
      tick(1);
      chk({irq_out, irq_oe}, {8'h01 << l, 8'h01 << l});
      ext_irq = 1'b0;
    end
    cfg(4'h9, 8'h0B);
    wr(11'h3F0, 8'hAA);
    pwr = 1'b0;
    ri_in = 1'b1;
    ser_irq = 1'b1;
    tick(1);
    chk({pins_oe, ri_out, irq_out, irq_oe}, 18'h10808);
    go(11'h200, 1'b1, 16'h0000, 1'b0);
    chk({game_n, sd_oe, flp_rd}, 10'h200);
    done();
    enter();
    pwr = 1'b1;
    tick(1);
    chk(cfg_mode, 1'b0);
    go(11'h200, 1'b1, 16'h0000, 1'b0);
    chk(game_n, 1'b0);
    done();
    strap = 1'b1;
    nrst = 1'b0;
    tick(1);
    nrst = 1'b1;
    tick(2);
    go(11'h200, 1'b1, 16'h0000, 1'b0);
    chk({game_n, irq_oe}, 9'h100);
    done();
    enter();
    chk(cfg_mode, 1'b0);
    wr(11'h370, 8'h55);
    wr(11'h370, 8'h55);
    chk(cfg_mode, 1'b1);
    wr(11'h370, 8'hAA);
    chk(cfg_mode, 1'b0);
    $display("test irq_and_power done");
  endtask
  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    tick(20000);
    fail_count++;
    report_and_stop();
  end
  initial begin
    nrst = 1'b0;
    pwr = 1'b1;
    ext_irq = 1'b0;
    ri_in = 1'b0;
    strap = 1'b0;
    ser_irq = 1'b0;
    tick(3);
    nrst = 1'b1;
    tick(2);
    t_reset();
    t_floppy();
    t_windows();
    t_irq_power();
    report_and_stop();
  end
endmodule // tb_top
